// ===== hdl/txcc_pkg.sv
// package: command word fields and constants of the transmit command checker
package txcc_pkg;
    localparam int A_OFS_HI   = 20;
    localparam int A_OFS_LO   = 16;
    localparam int A_FIRST    = 13;
    localparam int A_LAST     = 12;
    localparam int A_ALIGN_HI = 25;
    localparam int A_ALIGN_LO = 24;
    localparam int SIZE_HI    = 10;
    localparam int B_TAG_HI   = 31;
    localparam int B_TAG_LO   = 16;
    localparam int B_NOCRC    = 13;
    localparam int B_NOPAD    = 12;
    localparam int MIN_FRAME  = 64;
    localparam logic [1:0] ALIGN_4  = 2'h0;
    localparam logic [1:0] ALIGN_16 = 2'h1;
    localparam logic [1:0] ALIGN_32 = 2'h2;
    localparam logic [1:0] ALIGN_RS = 2'h3;
    localparam logic [31:0] A_RSVD_MASK = 32'h00e0c800;
    localparam logic [31:0] B_RSVD_MASK = 32'h0000c800;
    typedef enum logic [1:0] {
        TXCC_CMD_A = 2'b00,
        TXCC_CMD_B = 2'b01,
        TXCC_DATA  = 2'b10,
        TXCC_PAD   = 2'b11
    } txcc_state_t;
endpackage

// ===== hdl/txcc_byte_lane.sv
// byte-lane stripper: turns one data dword into a valid byte count
`timescale 1ns/1ps
module txcc_byte_lane
(
    // request
    input  wire logic [1:0]  first_lane,
    input  wire logic        is_first,
    input  wire logic [11:0] bytes_left,
    // answer
    output logic [2:0]       lane_count,
    output logic [3:0]       lane_mask
);
    logic [2:0] avail;
    logic [2:0] cnt;
    always_comb
    begin
        avail = is_first ? 3'(3'd4 - {1'b0, first_lane}) : 3'd4;
        if (bytes_left < 12'(avail))
            cnt = bytes_left[2:0];
        else
            cnt = avail;
        lane_count = cnt;
        lane_mask  = 4'(((5'h01 << cnt) - 5'h01) << (is_first ? first_lane
                                                           : 2'h0));
    end
endmodule

// ===== hdl/txcc_checker.sv
// transmit command word decoder and packet length checker
`timescale 1ns/1ps
module txcc_checker
#(
    parameter int LEN_W = 11
)
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // host dword stream
    input  wire logic [31:0]       wr_data,
    input  wire logic              wr_valid,
    // stripped data toward the transmit fifo
    output logic [31:0]            out_data,
    output logic [3:0]             out_lanes,
    output logic                   out_valid,
    output logic                   out_last,
    // per-packet controls and status
    output logic [15:0]            pkt_tag,
    output logic                   add_fcs,
    output logic                   add_pad,
    output logic                   pkt_done,
    output logic                   tx_error_flag,
    input  wire logic              tx_error_clear,
    output logic                   rsvd_bits_seen
);
    // sums and field slices are built for eleven length bits only
    if (LEN_W != 11)
    begin
        $error("txcc_checker: LEN_W must be 11");
    end

    // dwords spanned by offset plus size, then padded to the alignment
    function automatic logic [9:0] span_dwords(input logic [4:0] ofs,
                                               input logic [10:0] size,
                                               input logic [1:0] align);
        logic [11:0] raw;
        logic [9:0]  dw;
        logic [9:0]  gm;
        raw = 12'({1'b0, size}) + 12'(ofs) + 12'h003;
        dw  = raw[11:2];
        case (align)
            txcc_pkg::ALIGN_16: gm = 10'h003;
            txcc_pkg::ALIGN_32: gm = 10'h007;
            default:            gm = 10'h000;
        endcase
        span_dwords = (dw + gm) & ~gm;
    endfunction

    txcc_pkg::txcc_state_t state;
    txcc_pkg::txcc_state_t next_state;
    logic [31:0] word_a;
    logic [31:0] next_word_a;
    logic [31:0] word_b;
    logic [31:0] next_word_b;
    logic        in_pkt;
    logic        next_in_pkt;
    logic [11:0] size_sum;
    logic [11:0] next_size_sum;
    logic [11:0] sent_sum;
    logic [11:0] next_sent_sum;
    logic [11:0] bytes_left;
    logic [11:0] next_bytes_left;
    logic [9:0]  dw_left;
    logic [9:0]  next_dw_left;
    logic [2:0]  lead_dw;
    logic [2:0]  next_lead_dw;
    logic        first_dw;
    logic        next_first_dw;
    logic        err;
    logic        next_err;
    logic        rsvd;
    logic        next_rsvd;
    logic [31:0] o_data;
    logic [31:0] next_o_data;
    logic [3:0]  o_lanes;
    logic [3:0]  next_o_lanes;
    logic        o_valid;
    logic        next_o_valid;
    logic        o_last;
    logic        next_o_last;
    logic        done;
    logic        next_done;
    logic [2:0]  lane_count;
    logic [3:0]  lane_mask;

    txcc_byte_lane u_lane
    (
        .first_lane (word_a[txcc_pkg::A_OFS_LO+1:txcc_pkg::A_OFS_LO]),
        .is_first   (first_dw),
        .bytes_left (bytes_left),
        .lane_count (lane_count),
        .lane_mask  (lane_mask)
    );

    always_comb
    begin
        logic [11:0] sum;
        logic        fail;
        sum             = 12'h000;
        fail            = 1'b0;
        next_state      = state;
        next_word_a     = word_a;
        next_word_b     = word_b;
        next_in_pkt     = in_pkt;
        next_size_sum   = size_sum;
        next_sent_sum   = sent_sum;
        next_bytes_left = bytes_left;
        next_dw_left    = dw_left;
        next_lead_dw    = lead_dw;
        next_first_dw   = first_dw;
        next_err        = err;
        next_rsvd       = rsvd;
        next_o_data     = o_data;
        next_o_lanes    = o_lanes;
        next_o_valid    = 1'b0;
        next_o_last     = 1'b0;
        next_done       = 1'b0;
        if (wr_valid)
        begin
            case (state)
                txcc_pkg::TXCC_CMD_A:
                begin
                    next_word_a = wr_data;
                    next_state  = txcc_pkg::TXCC_CMD_B;
                    if ((wr_data & txcc_pkg::A_RSVD_MASK) != 32'h0)
                        next_rsvd = 1'b1;
                    if (wr_data[txcc_pkg::A_ALIGN_HI:txcc_pkg::A_ALIGN_LO]
                        == txcc_pkg::ALIGN_RS)
                        fail = 1'b1;
                    if (wr_data[txcc_pkg::A_FIRST])
                    begin
                        next_in_pkt   = 1'b1;
                        next_size_sum = 12'h000;
                        next_sent_sum = 12'h000;
                    end
                    else if (!in_pkt)
                        fail = 1'b1;
                end
                txcc_pkg::TXCC_CMD_B:
                begin
                    next_word_b = wr_data;
                    if ((wr_data & txcc_pkg::B_RSVD_MASK) != 32'h0)
                        next_rsvd = 1'b1;
                    // later buffers must repeat the packet's word B
                    if (!word_a[txcc_pkg::A_FIRST] && wr_data != word_b)
                        fail = 1'b1;
                    next_size_sum = size_sum
                        + 12'(word_a[txcc_pkg::SIZE_HI:0]);
                    next_bytes_left = 12'(word_a[txcc_pkg::SIZE_HI:0]);
                    next_lead_dw = word_a[txcc_pkg::A_OFS_HI:
                                          txcc_pkg::A_OFS_LO+2];
                    next_first_dw = 1'b1;
                    next_dw_left = span_dwords(
                        word_a[txcc_pkg::A_OFS_HI:txcc_pkg::A_OFS_LO],
                        word_a[txcc_pkg::SIZE_HI:0],
                        word_a[txcc_pkg::A_ALIGN_HI:txcc_pkg::A_ALIGN_LO]
                    );
                    if (next_dw_left == 10'h000)
                        next_state = txcc_pkg::TXCC_CMD_A;
                    else
                        next_state = txcc_pkg::TXCC_DATA;
                end
                txcc_pkg::TXCC_DATA, txcc_pkg::TXCC_PAD:
                begin
                    next_dw_left = dw_left - 10'h001;
                    if (lead_dw != 3'h0)
                        next_lead_dw = lead_dw - 3'h1;
                    else if (bytes_left != 12'h000)
                    begin
                        next_o_data     = wr_data;
                        next_o_lanes    = lane_mask;
                        next_o_valid    = 1'b1;
                        next_first_dw   = 1'b0;
                        next_bytes_left = bytes_left - 12'(lane_count);
                        next_sent_sum   = sent_sum + 12'(lane_count);
                        next_o_last = word_a[txcc_pkg::A_LAST]
                            && (bytes_left == 12'(lane_count));
                    end
                    else
                        next_state = txcc_pkg::TXCC_PAD;
                    if (dw_left == 10'h001)
                    begin
                        next_state = txcc_pkg::TXCC_CMD_A;
                        if (word_a[txcc_pkg::A_LAST])
                        begin
                            sum = 12'(word_b[txcc_pkg::SIZE_HI:0]);
                            next_in_pkt = 1'b0;
                            next_done   = 1'b1;
                            if (size_sum != sum)
                                fail = 1'b1;
                            if (next_sent_sum != sum)
                                fail = 1'b1;
                        end
                    end
                end
                default:
                    next_state = txcc_pkg::TXCC_CMD_A;
            endcase
        end
        // a new error wins over a clear in the same cycle
        if (tx_error_clear)
            next_err = 1'b0;
        if (fail)
            next_err = 1'b1;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state      <= txcc_pkg::TXCC_CMD_A;
            word_a     <= 32'h0;
            word_b     <= 32'h0;
            in_pkt     <= 1'b0;
            size_sum   <= 12'h000;
            sent_sum   <= 12'h000;
            bytes_left <= 12'h000;
            dw_left    <= 10'h000;
            lead_dw    <= 3'h0;
            first_dw   <= 1'b0;
            err        <= 1'b0;
            rsvd       <= 1'b0;
            o_data     <= 32'h0;
            o_lanes    <= 4'h0;
            o_valid    <= 1'b0;
            o_last     <= 1'b0;
            done       <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            word_a     <= next_word_a;
            word_b     <= next_word_b;
            in_pkt     <= next_in_pkt;
            size_sum   <= next_size_sum;
            sent_sum   <= next_sent_sum;
            bytes_left <= next_bytes_left;
            dw_left    <= next_dw_left;
            lead_dw    <= next_lead_dw;
            first_dw   <= next_first_dw;
            err        <= next_err;
            rsvd       <= next_rsvd;
            o_data     <= next_o_data;
            o_lanes    <= next_o_lanes;
            o_valid    <= next_o_valid;
            o_last     <= next_o_last;
            done       <= next_done;
        end
    end

    assign out_data      = o_data;
    assign out_lanes     = o_lanes;
    assign out_valid     = o_valid;
    assign out_last      = o_last;
    assign pkt_tag       = word_b[txcc_pkg::B_TAG_HI:txcc_pkg::B_TAG_LO];
    // disabling padding forces the check sequence back on
    assign add_fcs       = !word_b[txcc_pkg::B_NOCRC]
                           || word_b[txcc_pkg::B_NOPAD];
    assign add_pad       = !word_b[txcc_pkg::B_NOPAD];
    assign pkt_done      = done;
    assign tx_error_flag = err;
    assign rsvd_bits_seen = rsvd;
endmodule

// ===== testbench/txcc_checker_monitor.sv
// port assertions for the transmit command checker
`timescale 1ns/1ps
module txcc_checker_monitor
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // host side
    input wire logic [31:0] wr_data,
    input wire logic        wr_valid,
    input wire logic        tx_error_clear,
    // results
    input wire logic [31:0] out_data,
    input wire logic [3:0]  out_lanes,
    input wire logic        out_valid,
    input wire logic        out_last,
    input wire logic [15:0] pkt_tag,
    input wire logic        add_fcs,
    input wire logic        add_pad,
    input wire logic        pkt_done,
    input wire logic        tx_error_flag,
    input wire logic        rsvd_bits_seen
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // a quiet cycle first, so no late packet-end error is pending
    sequence s_clear_idle;
        !wr_valid ##1 (tx_error_clear && !wr_valid);
    endsequence
    property p_fcs_nopad; !add_pad |-> add_fcs; endproperty
    a_fcs_nopad: assert property (p_fcs_nopad)
        else $error("fcs off while padding off");
    property p_done_pulse; pkt_done |=> !pkt_done; endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("packet done longer than one cycle");
    property p_last_valid; out_last |-> out_valid; endproperty
    a_last_valid: assert property (p_last_valid)
        else $error("last marker without data");
    property p_lanes; out_valid |-> out_lanes != 4'h0; endproperty
    a_lanes: assert property (p_lanes)
        else $error("data dword with no lanes");
    property p_answer; out_valid |-> $past(wr_valid); endproperty
    a_answer: assert property (p_answer)
        else $error("data out without a dword taken");
    property p_err_hold;
        tx_error_flag && !tx_error_clear |=> tx_error_flag;
    endproperty
    a_err_hold: assert property (p_err_hold)
        else $error("error flag dropped without clear");
    property p_err_clear; s_clear_idle |=> !tx_error_flag; endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("error flag not cleared");
    property p_rsvd_hold; rsvd_bits_seen |=> rsvd_bits_seen; endproperty
    a_rsvd_hold: assert property (p_rsvd_hold)
        else $error("reserved marker dropped");
    property p_ctl_cause;
        $changed(pkt_tag) || $changed(add_fcs) || $changed(add_pad)
            |-> $past(wr_valid);
    endproperty
    a_ctl_cause: assert property (p_ctl_cause)
        else $error("packet controls changed with no word");
endmodule
bind txcc_checker txcc_checker_monitor u_txcc_checker_monitor
(
    .sys_clk(sys_clk), .rst_n(rst_n), .wr_data(wr_data),
    .wr_valid(wr_valid), .tx_error_clear(tx_error_clear),
    .out_data(out_data), .out_lanes(out_lanes), .out_valid(out_valid),
    .out_last(out_last), .pkt_tag(pkt_tag), .add_fcs(add_fcs),
    .add_pad(add_pad), .pkt_done(pkt_done),
    .tx_error_flag(tx_error_flag), .rsvd_bits_seen(rsvd_bits_seen)
);

// ===== testbench/txcc_host.sv
// host model writing command words and buffer dwords
`timescale 1ns/1ps
module txcc_host
(
    // clock
    input  wire logic   sys_clk,
    // dword stream
    output logic [31:0] wr_data,
    output logic        wr_valid
);
    initial
    begin
        wr_valid = 1'b0;
        wr_data  = 32'h0;
    end
    task automatic put(input logic [31:0] d);
        @(posedge sys_clk);
        #1;
        wr_valid = 1'b1;
        wr_data  = d;
    endtask
    // released bus shows inverted data, never a stale copy
    task automatic send(input logic [31:0] a, b, input int n);
        put(a);
        put(b);
        for (int i = 0; i < n; i++)
            put({4{i[7:0]}} ^ 32'h03020100);
        @(posedge sys_clk);
        #1;
        wr_valid = 1'b0;
        wr_data  = ~wr_data;
    endtask
endmodule

// ===== testbench/txcc_checker_test.sv
// self-checking bench for the transmit command checker
`timescale 1ns/1ps
module txcc_checker_test;
    logic        sys_clk, rst_n, tx_error_clear, wr_valid;
    logic [31:0] wr_data, out_data;
    logic [3:0]  out_lanes;
    logic [15:0] pkt_tag;
    logic        out_valid, out_last, add_fcs, add_pad;
    logic        pkt_done, tx_error_flag, rsvd_bits_seen;
    int          error_cnt, samples_checked, cyc, nbytes, ndone, nlast;
    logic [3:0]  lanes_q[$];
    logic [31:0] data_q[$];
    logic [3:0]  last_lanes;
    txcc_host u_txcc_host
    (
        .sys_clk(sys_clk), .wr_data(wr_data), .wr_valid(wr_valid)
    );
    txcc_checker u_txcc_checker
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .wr_data(wr_data),
        .wr_valid(wr_valid), .out_data(out_data), .out_lanes(out_lanes),
        .out_valid(out_valid), .out_last(out_last), .pkt_tag(pkt_tag),
        .add_fcs(add_fcs), .add_pad(add_pad), .pkt_done(pkt_done),
        .tx_error_flag(tx_error_flag), .tx_error_clear(tx_error_clear),
        .rsvd_bits_seen(rsvd_bits_seen)
    );
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (out_valid === 1'b1)
        begin
            lanes_q.push_back(out_lanes);
            data_q.push_back(out_data);
            nbytes <= nbytes + $countones(out_lanes);
        end
        if (out_last === 1'b1)
        begin
            nlast      <= nlast + 1;
            last_lanes <= out_lanes;
        end
        if (pkt_done === 1'b1)
            ndone <= ndone + 1;
        if (cyc == 3000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] exp, got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    function automatic logic [31:0] wa(input logic [1:0] al,
        input logic [4:0] ofs, input logic f, l, input logic [10:0] sz);
        return {6'h00, al, 3'h0, ofs, 2'h0, f, l, 1'h0, sz};
    endfunction
    function automatic logic [31:0] wb(input logic [15:0] tag,
        input logic nc, np, input logic [10:0] len);
        return {tag, 2'h0, nc, np, 1'h0, len};
    endfunction
    task automatic fresh();
        lanes_q.delete();
        data_q.delete();
        nbytes = 0;
        ndone  = 0;
        nlast  = 0;
        last_lanes = 4'h0;
    endtask
    task automatic finish_pkt(input logic err);
        for (int i = 0; i < 40 && ndone < 1; i++)
            @(posedge sys_clk);
        #1;
        chk(32'h1, 32'(ndone));
        chk(32'(err), 32'(tx_error_flag));
        @(posedge sys_clk);
        #1;
        tx_error_clear = 1'b1;
        @(posedge sys_clk);
        #1;
        tx_error_clear = 1'b0;
        chk(32'h0, 32'(tx_error_flag));
    endtask
    task automatic t_walk();
        fresh();
        u_txcc_host.send(wa(2'h0, 5'h01, 1, 1, 11'h005),
            wb(16'h1234, 0, 0, 11'h005), 2);
        finish_pkt(1'b0);
        chk(32'he, 32'(lanes_q[0]));
        chk(32'h3, 32'(lanes_q[1]));
        chk(32'h5, 32'(nbytes));
        chk(32'h1234, 32'(pkt_tag));
        chk(32'h3, {30'h0, add_fcs, add_pad});
        chk(32'h03020100, data_q[0]);
        chk(32'h02030001, data_q[1]);
        chk(32'h1, 32'(nlast));
        chk(32'h3, 32'(last_lanes));
        chk(32'h0, 32'(rsvd_bits_seen));
        $display("test walk done");
    endtask
    task automatic t_two_buf();
        fresh();
        u_txcc_host.send(wa(2'h1, 5'h06, 1, 0, 11'h003),
            wb(16'h0a0b, 1, 0, 11'h007), 4);
        u_txcc_host.send(wa(2'h2, 5'h00, 0, 1, 11'h004),
            wb(16'h0a0b, 1, 0, 11'h007), 8);
        finish_pkt(1'b0);
        chk(32'hc, 32'(lanes_q[0]));
        chk(32'h1, 32'(lanes_q[1]));
        chk(32'hf, 32'(lanes_q[2]));
        chk(32'h7, 32'(nbytes));
        chk(32'h1, {30'h0, add_fcs, add_pad});
        chk(32'h02030001, data_q[0]);
        chk(32'h03020100, data_q[2]);
        chk(32'h1, 32'(nlast));
        chk(32'hf, 32'(last_lanes));
        $display("test two buffers done");
    endtask
    task automatic t_len_err();
        fresh();
        u_txcc_host.send(wa(2'h0, 5'h00, 1, 1, 11'h004),
            wb(16'h0001, 0, 0, 11'h005), 1);
        finish_pkt(1'b1);
        $display("test length error done");
    endtask
    task automatic t_b_diff();
        fresh();
        u_txcc_host.send(wa(2'h0, 5'h00, 1, 0, 11'h004),
            wb(16'h0002, 0, 0, 11'h008), 1);
        u_txcc_host.send(wa(2'h0, 5'h00, 0, 1, 11'h004),
            wb(16'h0003, 0, 0, 11'h008), 1);
        finish_pkt(1'b1);
        $display("test word b mismatch done");
    endtask
    task automatic t_nopad();
        fresh();
        u_txcc_host.send(wa(2'h0, 5'h00, 1, 1, 11'h004) | 32'h00400000,
            wb(16'h0005, 1, 1, 11'h004), 1);
        finish_pkt(1'b0);
        chk(32'h2, {30'h0, add_fcs, add_pad});
        chk(32'h1, 32'(rsvd_bits_seen));
        chk(32'h5, 32'(pkt_tag));
        $display("test no padding done");
    endtask
    // mid-run reset must drop the sticky marker and the packet controls
    task automatic t_reset();
        @(posedge sys_clk);
        #1;
        rst_n = 1'b0;
        @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        chk(32'h0, 32'(rsvd_bits_seen));
        chk(32'h3, {30'h0, add_fcs, add_pad});
        chk(32'h0, 32'(pkt_tag));
        chk(32'h0, 32'(tx_error_flag));
        $display("test reset done");
    endtask
    task automatic t_rsvd_align();
        fresh();
        u_txcc_host.send(wa(2'h3, 5'h00, 1, 1, 11'h004),
            wb(16'h0006, 0, 0, 11'h004), 1);
        finish_pkt(1'b1);
        chk(32'h0, 32'(rsvd_bits_seen));
        $display("test reserved alignment done");
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        tx_error_clear = 1'b0;
        error_cnt = 0;
        samples_checked = 0;
        cyc = 0;
        fresh();
        repeat (3) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        t_walk();
        t_two_buf();
        t_len_err();
        t_b_diff();
        t_nopad();
        t_reset();
        t_rsvd_align();
        complete_run();
    end
endmodule
